// ---- logic/tpwm_defines.svh ----
`ifndef TPWM_DEFINES_SVH
`define TPWM_DEFINES_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TPWM_OFS_CTRL     8'h00
`define TPWM_OFS_COMPARE  8'h04
`define TPWM_OFS_COUNTER  8'h08
`define TPWM_OFS_STATUS   8'h0c
`define TPWM_OFS_PORT     8'h10
`define TPWM_OFS_ACTIVE   8'h14
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TPWM_CTRL_MODE_LSB   0
`define TPWM_CTRL_ACTION_LSB 2
`define TPWM_CTRL_CLKSEL_LSB 4
`define TPWM_STAT_OVF_BIT    0
`define TPWM_STAT_CMF_BIT    1
`define TPWM_PORT_DATA_BIT   0
`define TPWM_PORT_DIR_BIT    1
// ----------------------------------------------------------------
// Reset values and counter limits
// ----------------------------------------------------------------
`define TPWM_CTRL_RST    7'h00
`define TPWM_BYTE_RST    8'h00
`define TPWM_BOTTOM      8'h00
`define TPWM_MAX         8'hff
// ----------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------
`define TPWM_MODE_NORMAL 2'h0
`define TPWM_MODE_PHASE  2'h1
`define TPWM_MODE_CTC    2'h2
`define TPWM_MODE_FAST   2'h3
// ----------------------------------------------------------------
// Prescaler masks (tick when masked divider bits are all ones)
// ----------------------------------------------------------------
`define TPWM_DIV1    10'h000
`define TPWM_DIV8    10'h007
`define TPWM_DIV32   10'h01f
`define TPWM_DIV64   10'h03f
`define TPWM_DIV128  10'h07f
`define TPWM_DIV256  10'h0ff
`define TPWM_DIV1024 10'h3ff
`endif

// ---- logic/tpwm_pkg.sv ----
`default_nettype none
// ----------------------------------------------------------------
// Shared types
// ----------------------------------------------------------------
package tpwm_pkg;
   typedef struct packed {
      logic [2:0] clkSel;
      logic [1:0] outputActionCode;
      logic [1:0] waveformModeField;
   } tpwm_ctrl_t;

   typedef enum logic [1:0] {
      DIR_UP   = 2'b01,
      DIR_DOWN = 2'b10
   } tpwm_dir_t;
endpackage
`default_nettype wire

// ---- logic/tpwm_timer.sv ----
// Operation
// RULE_01 - Mode 3 counts up BOTTOM to MAX
// RULE_02 - Fast non-inverting: clear on match, set BOTTOM
// RULE_03 - Fast inverting: set on match, clear BOTTOM
// RULE_04 - Fast: counter clears tick after MAX
// RULE_05 - Fast: overflow flag set at MAX
// RULE_06 - Action two normal, three inverted PWM
// RULE_07 - Tick is clock divided by prescale
// RULE_08 - Fast period is 256 ticks
// RULE_09 - Fast compare BOTTOM gives narrow spike
// RULE_10 - Fast compare MAX gives constant level
// RULE_11 - Fast action one toggles on match
// RULE_12 - Fast compare value is double buffered
// RULE_13 - Pin driven only when direction output
// RULE_14 - Mode 1 counts up then down
// RULE_15 - Dual-slope: up-match and down-match act oppositely
// RULE_16 - Dual-slope holds MAX one tick, reverses
// RULE_17 - Dual-slope: overflow flag set at BOTTOM
// RULE_18 - Dual-slope period is 510 ticks
// RULE_19 - Dual-slope extremes give constant levels
// RULE_20 - At MAX output takes up-match level
// RULE_21 - Missed up-match still transitions at MAX
// RULE_22 - All updates qualified by timer tick
// RULE_23 - Action zero leaves pin to port
// RULE_24 - Buffered compare loads when counter hits MAX
//
// Local design decisions: register access over APB and the address map.
`include "tpwm_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module tpwm_timer (
   input  wire logic                    mclk,
   input  wire logic                    rst,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [7:0]              paddr,
   input  wire logic [31:0]             pwdata,
   output var  logic [31:0]             prdata,
   output var  logic                    pready,
   output var  logic                    pslverr,
   output var  tpwm_pkg::tpwm_ctrl_t    ctrlState,
   output var  logic                    waveformPinOut,
   output var  logic                    waveformPinOe
);
   import tpwm_pkg::*;

   // Divider mask per clock select; zero select stops the timer
   function automatic logic [9:0] divMask(input logic [2:0] sel);
      case (sel)
         3'h1:    divMask = `TPWM_DIV1;
         3'h2:    divMask = `TPWM_DIV8;
         3'h3:    divMask = `TPWM_DIV32;
         3'h4:    divMask = `TPWM_DIV64;
         3'h5:    divMask = `TPWM_DIV128;
         3'h6:    divMask = `TPWM_DIV256;
         default: divMask = `TPWM_DIV1024;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   tpwm_ctrl_t  ctrl_reg,         ctrl_next;
   logic [7:0]  compareValue_reg, compareValue_next;
   logic [7:0]  activeCmp_reg,    activeCmp_next;
   logic [7:0]  counterValue_reg, counterValue_next;
   tpwm_dir_t   dir_reg,          dir_next;
   logic        overflowFlag_reg, overflowFlag_next;
   logic        compareMatchFlag_reg, compareMatchFlag_next;
   logic        waveform_reg,     waveform_next;
   logic        portData_reg,     portData_next;
   logic        portDir_reg,      portDir_next;
   logic [9:0]  div_reg,          div_next;
   logic [31:0] prdata_reg,       prdata_next;
   logic        pready_reg,       pready_next;
   logic        pslverr_reg,      pslverr_next;
   logic        pinOut_reg,       pinOut_next;
   logic        pinOe_reg,        pinOe_next;

   logic        access;
   logic        wrEn;
   logic        stsWr;
   logic        mapped;
   logic        timerTick;
   logic        cmpHit;
   logic [1:0]  act;

   // ----------------------------------------------------------------
   // APB slave: one wait state, so all outputs come from flops
   // ----------------------------------------------------------------
   assign access = psel & penable;
   assign wrEn   = access & pwrite & pready_reg;
   assign stsWr  = wrEn && (paddr == `TPWM_OFS_STATUS);
   assign mapped = (paddr == `TPWM_OFS_CTRL)    || (paddr == `TPWM_OFS_COMPARE) ||
                   (paddr == `TPWM_OFS_COUNTER) || (paddr == `TPWM_OFS_STATUS)  ||
                   (paddr == `TPWM_OFS_PORT)    || (paddr == `TPWM_OFS_ACTIVE);

   // Answer and read data prepared in the first access cycle
   always_comb begin
      pready_next  = access & ~pready_reg;
      pslverr_next = 1'b0;
      prdata_next  = prdata_reg;
      if (access && !pready_reg) begin
         pslverr_next = ~mapped;
         case (paddr)
            `TPWM_OFS_CTRL:    prdata_next = {25'h0, ctrl_reg};
            `TPWM_OFS_COMPARE: prdata_next = {24'h0, compareValue_reg};
            `TPWM_OFS_COUNTER: prdata_next = {24'h0, counterValue_reg};
            `TPWM_OFS_STATUS:  prdata_next = {30'h0, compareMatchFlag_reg,
                                              overflowFlag_reg};
            `TPWM_OFS_PORT:    prdata_next = {30'h0, portDir_reg, portData_reg};
            `TPWM_OFS_ACTIVE:  prdata_next = {24'h0, activeCmp_reg};
            default:           prdata_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0;
      end else begin
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg  <= prdata_next;
      end
   end

   // ----------------------------------------------------------------
   // Prescaler and timer tick
   // ----------------------------------------------------------------
   // Free divider; a clock select change may shorten the first tick
   assign timerTick = (ctrl_reg.clkSel != 3'h0) &&
                      ((div_reg & divMask(ctrl_reg.clkSel)) == divMask(ctrl_reg.clkSel)); // RULE_07

   always_comb begin
      div_next = (ctrl_reg.clkSel == 3'h0) ? 10'h000 : div_reg + 10'h001;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         div_reg <= 10'h000;
      end else begin
         div_reg <= div_next;
      end
   end

   // ----------------------------------------------------------------
   // Counter, compare unit and waveform generator
   // ----------------------------------------------------------------
   assign act    = ctrl_reg.outputActionCode;
   assign cmpHit = (counterValue_reg == activeCmp_reg);

   always_comb begin
      ctrl_next             = ctrl_reg;
      compareValue_next     = compareValue_reg;
      activeCmp_next        = activeCmp_reg;
      counterValue_next     = counterValue_reg;
      dir_next              = dir_reg;
      waveform_next         = waveform_reg;
      portData_next         = portData_reg;
      portDir_next          = portDir_reg;
      // Flags gather set events here; the held value is merged last
      overflowFlag_next     = 1'b0;
      compareMatchFlag_next = 1'b0;
      // Non-PWM modes use the compare value unbuffered
      if (ctrl_reg.waveformModeField == `TPWM_MODE_NORMAL ||
          ctrl_reg.waveformModeField == `TPWM_MODE_CTC) begin
         activeCmp_next = compareValue_reg;
         dir_next       = DIR_UP;
      end
      if (timerTick) begin // RULE_22
         if (cmpHit) begin
            compareMatchFlag_next = 1'b1;
         end
         case (ctrl_reg.waveformModeField)
            `TPWM_MODE_FAST: begin
               // Single slope, 256 states per period
               if (counterValue_reg == `TPWM_MAX) begin // RULE_01 RULE_08
                  counterValue_next = `TPWM_BOTTOM; // RULE_04
                  overflowFlag_next = 1'b1; // RULE_05
                  activeCmp_next    = compareValue_reg; // RULE_12 RULE_24
               end else begin
                  counterValue_next = counterValue_reg + 8'h01;
               end
               if (act == 2'h1 && cmpHit) begin
                  waveform_next = ~waveform_reg; // RULE_11
               end else if (act[1]) begin // RULE_06
                  // BOTTOM action wins so compare MAX stays constant
                  if (counterValue_reg == `TPWM_MAX) begin
                     waveform_next = ~act[0]; // RULE_02 RULE_03 RULE_10
                  end else if (cmpHit) begin
                     waveform_next = act[0]; // RULE_02 RULE_03 RULE_09
                  end
               end
            end
            `TPWM_MODE_PHASE: begin
               // Dual slope, 510 ticks per period
               if (dir_reg == DIR_UP) begin // RULE_14 RULE_18
                  if (counterValue_reg == `TPWM_MAX) begin
                     dir_next          = DIR_DOWN; // RULE_16
                     counterValue_next = `TPWM_MAX - 8'h01;
                     activeCmp_next    = compareValue_reg; // RULE_24
                     // Level at MAX is the up-match result unless compare is MAX
                     if (act[1]) begin
                        waveform_next = (compareValue_reg == `TPWM_MAX) ?
                                        ~act[0] : act[0]; // RULE_20 RULE_21
                     end
                  end else begin
                     counterValue_next = counterValue_reg + 8'h01;
                     if (act[1] && cmpHit) begin
                        waveform_next = act[0]; // RULE_15
                     end
                  end
               end else begin
                  if (counterValue_reg == `TPWM_BOTTOM) begin
                     dir_next          = DIR_UP;
                     counterValue_next = `TPWM_BOTTOM + 8'h01;
                     overflowFlag_next = 1'b1; // RULE_17
                     // Match at BOTTOM counts as up-match: compare 0 stays low non-inverting, high inverting
                     if (act[1] && cmpHit) begin
                        waveform_next = act[0]; // RULE_19
                     end
                  end else begin
                     counterValue_next = counterValue_reg - 8'h01;
                     if (act[1] && cmpHit) begin
                        waveform_next = ~act[0]; // RULE_15 RULE_19
                     end
                  end
               end
            end
            `TPWM_MODE_CTC: begin
               counterValue_next = cmpHit ? `TPWM_BOTTOM : counterValue_reg + 8'h01;
               if (counterValue_reg == `TPWM_MAX) begin
                  overflowFlag_next = 1'b1;
               end
               if (cmpHit && act != 2'h0) begin
                  waveform_next = (act == 2'h1) ? ~waveform_reg : act[0];
               end
            end
            default: begin
               counterValue_next = counterValue_reg + 8'h01;
               if (counterValue_reg == `TPWM_MAX) begin
                  overflowFlag_next = 1'b1;
               end
               if (cmpHit && act != 2'h0) begin
                  waveform_next = (act == 2'h1) ? ~waveform_reg : act[0];
               end
            end
         endcase
      end
      // Software writes; flag set beats a same-cycle clear
      if (wrEn) begin
         case (paddr)
            `TPWM_OFS_CTRL:    ctrl_next = pwdata[6:0];
            `TPWM_OFS_COMPARE: compareValue_next = pwdata[7:0];
            `TPWM_OFS_COUNTER: counterValue_next = pwdata[7:0];
            `TPWM_OFS_PORT: begin
               portData_next = pwdata[`TPWM_PORT_DATA_BIT];
               portDir_next  = pwdata[`TPWM_PORT_DIR_BIT];
            end
            default: begin
            end
         endcase
      end
      // Set event wins over a write-one clear in the same cycle
      overflowFlag_next     = overflowFlag_next |
                              (overflowFlag_reg & ~(stsWr & pwdata[`TPWM_STAT_OVF_BIT]));
      compareMatchFlag_next = compareMatchFlag_next |
                              (compareMatchFlag_reg & ~(stsWr & pwdata[`TPWM_STAT_CMF_BIT]));
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_reg             <= `TPWM_CTRL_RST;
         compareValue_reg     <= `TPWM_BYTE_RST;
         activeCmp_reg        <= `TPWM_BYTE_RST;
         counterValue_reg     <= `TPWM_BYTE_RST;
         dir_reg              <= DIR_UP;
         waveform_reg         <= 1'b0;
         portData_reg         <= 1'b0;
         portDir_reg          <= 1'b0;
         overflowFlag_reg     <= 1'b0;
         compareMatchFlag_reg <= 1'b0;
      end else begin
         ctrl_reg             <= ctrl_next;
         compareValue_reg     <= compareValue_next;
         activeCmp_reg        <= activeCmp_next;
         counterValue_reg     <= counterValue_next;
         dir_reg              <= dir_next;
         waveform_reg         <= waveform_next;
         portData_reg         <= portData_next;
         portDir_reg          <= portDir_next;
         overflowFlag_reg     <= overflowFlag_next;
         compareMatchFlag_reg <= compareMatchFlag_next;
      end
   end

   // ----------------------------------------------------------------
   // Port pin override
   // ----------------------------------------------------------------
   // One flop of lag keeps the pin glitch-free from the waveform flop
   always_comb begin
      pinOut_next = (act != 2'h0) ? waveform_reg : portData_reg; // RULE_23
      pinOe_next  = portDir_reg; // RULE_13
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pinOut_reg <= 1'b0;
         pinOe_reg  <= 1'b0;
      end else begin
         pinOut_reg <= pinOut_next;
         pinOe_reg  <= pinOe_next;
      end
   end

   assign prdata         = prdata_reg;
   assign pready         = pready_reg;
   assign pslverr        = pslverr_reg;
   assign ctrlState      = ctrl_reg;
   assign waveformPinOut = pinOut_reg;
   assign waveformPinOe  = pinOe_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   logic cntWr;
   assign cntWr = wrEn && paddr == `TPWM_OFS_COUNTER;
   logic fastMax;
   assign fastMax = timerTick && ctrl_reg.waveformModeField == `TPWM_MODE_FAST &&
                    counterValue_reg == `TPWM_MAX;
   logic phaseMax;
   assign phaseMax = timerTick && ctrl_reg.waveformModeField == `TPWM_MODE_PHASE &&
                     dir_reg == DIR_UP && counterValue_reg == `TPWM_MAX;

   property p_fastWrap;
      fastMax && !cntWr |=> counterValue_reg == `TPWM_BOTTOM;
   endproperty
   a_fastWrap: assert property (p_fastWrap) else $error("fast wrap missed"); // RULE_04

   property p_fastOvf;
      fastMax |=> overflowFlag_reg;
   endproperty
   a_fastOvf: assert property (p_fastOvf) else $error("fast overflow missed"); // RULE_05

   property p_phaseOvf;
      timerTick && ctrl_reg.waveformModeField == `TPWM_MODE_PHASE && dir_reg == DIR_DOWN &&
      counterValue_reg == `TPWM_BOTTOM |=> overflowFlag_reg && dir_reg == DIR_UP;
   endproperty
   a_phaseOvf: assert property (p_phaseOvf) else $error("bottom overflow missed"); // RULE_17

   property p_phaseTurn;
      phaseMax && !cntWr |=> counterValue_reg == 8'hfe && dir_reg == DIR_DOWN;
   endproperty
   a_phaseTurn: assert property (p_phaseTurn) else $error("no turn at max"); // RULE_16

   property p_holdNoTick;
      !timerTick && !cntWr |=> $stable(counterValue_reg);
   endproperty
   a_holdNoTick: assert property (p_holdNoTick) else $error("count without tick"); // RULE_22

   property p_fastSet;
      fastMax && act == 2'h2 && !(wrEn && paddr == `TPWM_OFS_CTRL)
      |=> waveform_reg ##1 pinOut_reg;
   endproperty
   a_fastSet: assert property (p_fastSet) else $error("bottom set missed"); // RULE_02

   property p_fastClr;
      fastMax && act == 2'h3 |=> !waveform_reg;
   endproperty
   a_fastClr: assert property (p_fastClr) else $error("bottom clear missed"); // RULE_03

   property p_portOnly;
      act == 2'h0 && $stable(ctrl_reg) |=> pinOut_reg == $past(portData_reg);
   endproperty
   a_portOnly: assert property (p_portOnly) else $error("pin not port data"); // RULE_23

   property p_pinDir;
      ##1 waveformPinOe == $past(portDir_reg);
   endproperty
   a_pinDir: assert property (p_pinDir) else $error("pin enable wrong"); // RULE_13

   property p_loadCmp;
      (fastMax || phaseMax) && !(wrEn && paddr == `TPWM_OFS_CTRL)
      |=> activeCmp_reg == $past(compareValue_reg);
   endproperty
   a_loadCmp: assert property (p_loadCmp) else $error("compare not loaded"); // RULE_24

   property p_phaseMaxLvl;
      phaseMax && act == 2'h2 && compareValue_reg != `TPWM_MAX |=> !waveform_reg;
   endproperty
   a_phaseMaxLvl: assert property (p_phaseMaxLvl) else $error("max level wrong"); // RULE_20

   c_fastWrap:  cover property (fastMax ##1 counterValue_reg == `TPWM_BOTTOM);
   c_phaseTurn: cover property (phaseMax ##1 dir_reg == DIR_DOWN);
   c_readDone:  cover property (psel && penable && pready && !pwrite);
   c_pinHigh:   cover property (waveformPinOe && waveformPinOut);

endmodule // tpwm_timer
`default_nettype wire

// ---- tb/tpwm_pin_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Board side of the waveform pin
// ----------------------------------------------------------------
module tpwm_pin_model (
   input  wire logic pinOut,
   input  wire logic pinOe,
   output var  logic pinLevel
);
   // Weak pull-down: an undriven pin must not keep its last level
   always_comb begin
      pinLevel = pinOe ? pinOut : 1'b0;
   end
endmodule // tpwm_pin_model
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "tpwm_defines.svh"
module tb;
   import tpwm_pkg::*;
   logic                 mclk, rst, psel, penable, pwrite, pready, pslverr;
   logic                 pinOut, pinOe, pinLevel;
   logic [7:0]           paddr, lfsr;
   logic [31:0]          pwdata, prdata;
   tpwm_ctrl_t           ctrlState;
   logic [32:0]          expQ[$];
   int                   mismatches, checked, measLen, highs, win, n, c, want;
   event                 measGo, measDone;
   logic [6:0]           cfgs [11] = '{7'h1b, 7'h1b, 7'h1f, 7'h3b, 7'h17, 7'h13, 7'h1b,
                                       7'h19, 7'h19, 7'h1d, 7'h29};
   logic [1:0]           ports [11] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h3, 2'h0,
                                        2'h2, 2'h2, 2'h2, 2'h2};
   int                   cmps [11] = '{0, 255, -1, -1, 64, 0, 255, 0, 255, -1, -1};

   tpwm_timer u_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ctrlState(ctrlState), .waveformPinOut(pinOut),
      .waveformPinOe(pinOe));
   tpwm_pin_model u_pin (.pinOut(pinOut), .pinOe(pinOe), .pinLevel(pinLevel));

   // 40 MHz clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // ----------------------------------------------------------------
   // Checking and closing
   // ----------------------------------------------------------------
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("Counts: checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   function automatic logic [7:0] nextRand(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction
   // ----------------------------------------------------------------
   // APB master, every change just after a rising edge
   // ----------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // Hold the request until pready is seen high at a rising edge
      do @(posedge mclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [32:0] exp);
      expQ.push_back(exp);
      apb(1'b0, a, 32'h0);
   endtask
   // ----------------------------------------------------------------
   // Monitors: read answers and pin duty, oldest note first
   // ----------------------------------------------------------------
   always @(posedge mclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         check({pslverr, prdata}, expQ.pop_front());
      end
   end

   initial begin
      forever begin
         @(measGo);
         highs = 0;
         repeat (measLen) begin
            @(negedge mclk);
            if (pinLevel === 1'b1) highs++;
         end
         check(33'(highs), expQ.pop_front());
         -> measDone;
      end
   end

   // Hang guard, sized well above the longest settle and measure spans
   initial begin
      repeat (90000) @(posedge mclk);
      mismatches++;
      report_and_stop();
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      rst = 1'b1;
      lfsr = 8'h49;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      // Reset values, unmapped slot, read-only active compare
      for (int a = 0; a < 24; a += 4) rd(8'(a), 33'h0);
      rd(8'h18, 33'h1_0000_0000);
      apb(1'b1, `TPWM_OFS_ACTIVE, 32'hff);
      // Stopped fast mode: a compare write must wait for MAX
      apb(1'b1, `TPWM_OFS_CTRL, 32'h03);
      apb(1'b1, `TPWM_OFS_COMPARE, 32'h5a);
      rd(`TPWM_OFS_COMPARE, 33'h5a);
      rd(`TPWM_OFS_ACTIVE, 33'h0);
      $display("Test registers done");
      // Duty over one whole period for fast and phase modes, each polarity and dividers 1, 8 and 32
      foreach (cfgs[i]) begin
         lfsr = nextRand(lfsr);
         c = (cmps[i] < 0) ? int'(lfsr) : cmps[i];
         n = (cfgs[i][6:4] == 3'h1) ? 1 : (cfgs[i][6:4] == 3'h2) ? 8 : 32;
         win = ((cfgs[i][1:0] == 2'h1) ? 510 : (cfgs[i][3:2] == 2'h1) ? 512 : 256) * n;
         case ({cfgs[i][1:0], cfgs[i][3:2]})
            4'b1110: want = (c + 1) * n;
            4'b1111: want = (255 - c) * n;
            4'b1101: want = 256 * n;
            4'b0110: want = 2 * c * n;
            4'b0111: want = (510 - 2 * c) * n;
            default: want = ports[i][0] ? win : 0;
         endcase
         if (!ports[i][1]) want = 0;
         apb(1'b1, `TPWM_OFS_COMPARE, 32'(c));
         apb(1'b1, `TPWM_OFS_PORT, 32'(ports[i]));
         apb(1'b1, `TPWM_OFS_CTRL, 32'(cfgs[i]));
         repeat (3 * win) @(posedge mclk);
         measLen = win;
         expQ.push_back(33'(want));
         -> measGo;
         @(measDone);
         rd(`TPWM_OFS_ACTIVE, 33'(c));
         $display("Test duty case %0d done", i);
      end
      // Flags per PWM mode: stop so no set races the clear, then run a period
      for (int m = 0; m < 2; m++) begin
         apb(1'b1, `TPWM_OFS_CTRL, m ? 32'h01 : 32'h03);
         apb(1'b1, `TPWM_OFS_STATUS, 32'h3);
         rd(`TPWM_OFS_STATUS, 33'h0);
         apb(1'b1, `TPWM_OFS_CTRL, m ? 32'h19 : 32'h1b);
         repeat (600) @(posedge mclk);
         rd(`TPWM_OFS_STATUS, 33'h3);
      end
      $display("Test flags done");
      report_and_stop();
   end
endmodule // tb
`default_nettype wire
